// ---- inc/ast_pkg.sv ----
// Function
// - rx_full_flag sets on good reception; clears by armed write-0 or holding read
// - overrun_flag sets on overrun; clears only by armed write-0
// - clearing rx_on leaves overrun_flag untouched
// - on overrun the older character stays; the new one is dropped
// - receiver stalls while overrun_flag or framing_flag is 1
// - framing_flag sets on bad stop bit; armed write-0 clears; rx_on ignored
// - only the first stop bit is checked for 1
// - framing error still loads receive_holding but leaves rx_full_flag alone
// - parity_error_flag clears only by armed write-0
// - writing 1 to a write-0-clear flag does nothing
// - transmit_holding resets to ff and is forced to ff in low-power modes
// - empty transmit_shifter takes the holding character and starts sending
// - waiting character follows the current frame with no idle gap
// - tx_buffer_empty_flag sets while tx_on is 0 and on each transfer
// - tx_buffer_empty_flag clears by armed write-0 or holding write
// - tx_on 0 holds the empty flag at 1; with tx_on 1 a holding write starts transmission
// - mp_bit_to_send is sent as the multiprocessor bit of each character
// - tx_complete_flag sets when tx_on is 0 or empty at last bit
// - tx_complete_flag clears by armed write-0 of empty flag or holding write
// - port control bit 4 picks general I/O or serial transmit output
// - transmit-empty and transmit-end requests follow their flags and enables
// - receive-full and receive-error requests follow their flags and enables
package ast_pkg;

	localparam int unsigned CLK_HZ    = 50_000_000;
	localparam int unsigned BAUD_RATE = 31_250;
	localparam logic [10:0] BIT_CYCLES  = 11'(CLK_HZ / BAUD_RATE);
	localparam logic [10:0] HALF_CYCLES = 11'(CLK_HZ / BAUD_RATE / 2);

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_PORT_CTRL = 16'hff91;
	localparam logic [15:0] IDX_MODE      = 16'hff98;
	localparam logic [15:0] IDX_CONTROL   = 16'hff9a;
	localparam logic [15:0] IDX_HOLDING   = 16'hff9b;
	localparam logic [15:0] IDX_STATUS    = 16'hff9c;
	localparam logic [15:0] IDX_RX_HOLD   = 16'hff9d;
	localparam int unsigned ADDR_W        = 18;

	localparam int unsigned BIT_PIN_SEL   = 4;
	localparam int unsigned BIT_PIN_INV   = 1;
	localparam int unsigned BIT_STOP_TWO  = 3;
	localparam int unsigned BIT_TX_IE     = 7;
	localparam int unsigned BIT_RX_IE     = 6;
	localparam int unsigned BIT_TX_ON     = 5;
	localparam int unsigned BIT_RX_ON     = 4;
	localparam int unsigned BIT_TX_COMPLETE_FLAG_IE   = 2;
	localparam int unsigned BIT_TX_BUFFER_EMPTY_FLAG      = 7;
	localparam int unsigned BIT_RX_FULL_FLAG      = 6;
	localparam int unsigned BIT_OER       = 5;
	localparam int unsigned BIT_FER       = 4;
	localparam int unsigned BIT_PER       = 3;
	localparam int unsigned BIT_TX_COMPLETE_FLAG      = 2;
	localparam int unsigned BIT_MPBR      = 1;
	localparam int unsigned BIT_MP_BIT_TO_SEND      = 0;

	localparam logic [7:0] HOLDING_RESET = 8'hff;
	localparam logic [7:0] STATUS_RESET  = 8'h84;

	typedef struct packed {
		logic tx_empty;
		logic rx_full;
		logic overrun;
		logic framing;
		logic parity;
		logic tx_done;
		logic mp_rx;
		logic mp_tx;
	} ast_status_t;

	typedef struct packed {
		logic tx_empty_irq;
		logic tx_done_irq;
		logic rx_full_irq;
		logic rx_error_irq;
	} ast_irq_t;

	typedef enum logic [4:0] {
		LS_IDLE  = 5'b0_0001,
		LS_START = 5'b0_0010,
		LS_DATA  = 5'b0_0100,
		LS_MPB   = 5'b0_1000,
		LS_STOP  = 5'b1_0000
	} ast_line_t;

endpackage

// ---- rtl/ast_serial.sv ----
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ast_serial (
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ast_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    low_power_req,
	input  wire logic                    serial_rx_in,
	input  wire logic                    gpio_dout,
	input  wire logic                    gpio_oe,
	output logic                         serial_tx_out,
	output logic                         serial_tx_oe,
	output ast_pkg::ast_irq_t            irq_out
);
	import ast_pkg::*;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		s = 3'd7;
		if (a[1:0] == 2'b00) begin
			unique case (a[ADDR_W-1:2])
				IDX_PORT_CTRL: s = 3'd0;
				IDX_MODE:      s = 3'd1;
				IDX_CONTROL:   s = 3'd2;
				IDX_HOLDING:   s = 3'd3;
				IDX_STATUS:    s = 3'd4;
				IDX_RX_HOLD:   s = 3'd5;
				default:       s = 3'd7;
			endcase
		end
		return s;
	endfunction

	logic [7:0]  port_ctrl_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  control_reg;
	logic [7:0]  holding_reg;
	logic [7:0]  rx_hold_reg;
	ast_status_t status_reg;
	ast_status_t armed_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	ast_irq_t    irq_reg;

	logic [2:0] sel;
	logic       access;
	logic       wr;
	logic       rd;
	logic       tx_on;
	logic       rx_on;
	assign sel    = reg_sel(paddr);
	assign access = psel & penable;
	assign wr     = access & pwrite & (sel != 3'd7);
	assign rd     = access & ~pwrite;
	assign tx_on  = control_reg[BIT_TX_ON];
	assign rx_on  = control_reg[BIT_RX_ON];

	logic hold_wr;
	logic status_wr;
	logic rx_hold_rd;
	logic w0c_tx_buffer_empty_flag;
	logic w0c_rx_full_flag;
	logic w0c_oer;
	logic w0c_fer;
	logic w0c_per;
	assign hold_wr    = wr && sel == 3'd3;
	assign status_wr  = wr && sel == 3'd4;
	assign rx_hold_rd = rd && sel == 3'd5;
	// a zero written without an earlier read of one is ignored
	assign w0c_tx_buffer_empty_flag = status_wr & ~pwdata[BIT_TX_BUFFER_EMPTY_FLAG] & armed_reg.tx_empty;
	assign w0c_rx_full_flag = status_wr & ~pwdata[BIT_RX_FULL_FLAG] & armed_reg.rx_full;
	assign w0c_oer  = status_wr & ~pwdata[BIT_OER] & armed_reg.overrun;
	assign w0c_fer  = status_wr & ~pwdata[BIT_FER] & armed_reg.framing;
	assign w0c_per  = status_wr & ~pwdata[BIT_PER] & armed_reg.parity;

	// one wait-free access; read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_reg <= (sel == 3'd7);
			unique case (sel)
				3'd0:    prdata_reg <= {24'h00_0000, port_ctrl_reg};
				3'd1:    prdata_reg <= {24'h00_0000, mode_reg};
				3'd2:    prdata_reg <= {24'h00_0000, control_reg};
				3'd3:    prdata_reg <= {24'h00_0000, holding_reg};
				3'd4:    prdata_reg <= {24'h00_0000, status_reg};
				3'd5:    prdata_reg <= {24'h00_0000, rx_hold_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_ctrl_reg <= 8'h00;
			mode_reg      <= 8'h00;
			control_reg   <= 8'h00;
		end else if (wr) begin
			if (sel == 3'd0) port_ctrl_reg <= pwdata[7:0];
			if (sel == 3'd1) mode_reg <= pwdata[7:0];
			if (sel == 3'd2) control_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			holding_reg <= HOLDING_RESET;
		end else if (low_power_req) begin
			holding_reg <= HOLDING_RESET;
		end else if (hold_wr) begin
			holding_reg <= pwdata[7:0];
		end
	end

	// read-as-one arming, dropped by any status write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= '0;
		end else if (status_wr) begin
			armed_reg <= '0;
		end else if (rd && sel == 3'd4) begin
			armed_reg <= armed_reg | ast_status_t'(prdata_reg[7:0]);
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	ast_line_t  tx_state;
	logic [10:0] tx_baud;
	logic [3:0]  tx_bit;
	logic [7:0]  tx_shift;
	logic        tx_mpb;
	logic        tx_line;
	logic        tx_bit_end;
	logic        tx_last;
	logic        tx_load;
	assign tx_bit_end = (tx_baud == BIT_CYCLES - 11'd1);
	assign tx_last    = tx_state == LS_STOP && tx_bit_end && (tx_bit == 4'd1 || !mode_reg[BIT_STOP_TWO]);
	// next character goes straight in at the end of the last stop bit
	assign tx_load = tx_on && !status_reg.tx_empty && (tx_state == LS_IDLE || tx_last);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= LS_IDLE;
			tx_baud  <= 11'd0;
			tx_bit   <= 4'd0;
			tx_shift <= 8'hff;
			tx_mpb   <= 1'b1;
		end else if (tx_load) begin
			tx_state <= LS_START;
			tx_baud  <= 11'd0;
			tx_bit   <= 4'd0;
			tx_shift <= holding_reg;
			tx_mpb   <= status_reg.mp_tx;
		end else if (tx_state == LS_IDLE) begin
			tx_baud <= 11'd0;
		end else if (!tx_bit_end) begin
			tx_baud <= tx_baud + 11'd1;
		end else begin
			tx_baud <= 11'd0;
			unique case (tx_state)
				LS_START: tx_state <= LS_DATA;
				LS_DATA: begin
					tx_shift <= {1'b1, tx_shift[7:1]};
					tx_bit   <= tx_bit + 4'd1;
					if (tx_bit == 4'd7) begin
						tx_state <= LS_MPB;
						tx_bit   <= 4'd0;
					end
				end
				LS_MPB:  tx_state <= LS_STOP;
				LS_STOP: begin
					tx_bit <= tx_bit + 4'd1;
					if (tx_last) tx_state <= LS_IDLE;
				end
				default: tx_state <= LS_IDLE;
			endcase
		end
	end

	always_comb begin
		unique case (tx_state)
			LS_START: tx_line = 1'b0;
			LS_DATA:  tx_line = tx_shift[0];
			LS_MPB:   tx_line = tx_mpb;
			default:  tx_line = 1'b1;
		endcase
	end

	// pin mux registered so the pin never glitches between roles
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serial_tx_out <= 1'b1;
			serial_tx_oe  <= 1'b0;
		end else if (port_ctrl_reg[BIT_PIN_SEL]) begin
			serial_tx_out <= tx_line ^ port_ctrl_reg[BIT_PIN_INV];
			serial_tx_oe  <= 1'b1;
		end else begin
			serial_tx_out <= gpio_dout;
			serial_tx_oe  <= gpio_oe;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	ast_line_t   rx_state;
	logic [10:0] rx_baud;
	logic [3:0]  rx_bit;
	logic [7:0]  rx_shift;
	logic        rx_mpb;
	logic        rx_sample;
	logic        rx_done;
	logic        rx_stall;
	assign rx_sample = (rx_baud == BIT_CYCLES - 11'd1);
	// only the first stop bit is sampled; a second one is left to idle
	assign rx_done   = rx_state == LS_STOP && rx_sample;
	assign rx_stall  = status_reg.overrun | status_reg.framing;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= LS_IDLE;
			rx_baud  <= 11'd0;
			rx_bit   <= 4'd0;
			rx_shift <= 8'h00;
			rx_mpb   <= 1'b0;
		end else if (!rx_on || rx_stall) begin
			rx_state <= LS_IDLE;
			rx_baud  <= 11'd0;
		end else begin
			unique case (rx_state)
				LS_IDLE: begin
					rx_baud <= 11'd0;
					if (!serial_rx_in) rx_state <= LS_START;
				end
				LS_START: begin
					rx_baud <= rx_baud + 11'd1;
					if (rx_baud == HALF_CYCLES - 11'd1) begin
						rx_baud  <= 11'd0;
						rx_bit   <= 4'd0;
						rx_state <= serial_rx_in ? LS_IDLE : LS_DATA;
					end
				end
				LS_DATA: begin
					rx_baud <= rx_sample ? 11'd0 : rx_baud + 11'd1;
					if (rx_sample) begin
						rx_shift <= {serial_rx_in, rx_shift[7:1]};
						rx_bit   <= rx_bit + 4'd1;
						if (rx_bit == 4'd7) rx_state <= LS_MPB;
					end
				end
				LS_MPB: begin
					rx_baud <= rx_sample ? 11'd0 : rx_baud + 11'd1;
					if (rx_sample) begin
						rx_mpb   <= serial_rx_in;
						rx_state <= LS_STOP;
					end
				end
				LS_STOP: begin
					rx_baud <= rx_sample ? 11'd0 : rx_baud + 11'd1;
					if (rx_sample) rx_state <= LS_IDLE;
				end
				default: rx_state <= LS_IDLE;
			endcase
		end
	end

	logic rx_frame_err;
	logic rx_overrun;
	logic rx_good;
	assign rx_frame_err = rx_done && !serial_rx_in;
	assign rx_overrun   = rx_done && serial_rx_in && status_reg.rx_full;
	assign rx_good      = rx_done && serial_rx_in && !status_reg.rx_full;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_hold_reg <= 8'h00;
		end else if (rx_good || rx_frame_err) begin
			rx_hold_reg <= rx_shift;
		end
	end

	// ----------------------------------------
	// status flags; a hardware set beats a clear
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= ast_status_t'(STATUS_RESET);
		end else begin
			if (!tx_on || tx_load) status_reg.tx_empty <= 1'b1;
			else if (hold_wr || w0c_tx_buffer_empty_flag) status_reg.tx_empty <= 1'b0;
			if (!tx_on || (tx_last && status_reg.tx_empty)) status_reg.tx_done <= 1'b1;
			else if (hold_wr || w0c_tx_buffer_empty_flag) status_reg.tx_done <= 1'b0;
			if (rx_good) status_reg.rx_full <= 1'b1;
			else if (w0c_rx_full_flag || rx_hold_rd) status_reg.rx_full <= 1'b0;
			if (rx_overrun) status_reg.overrun <= 1'b1;
			else if (w0c_oer) status_reg.overrun <= 1'b0;
			if (rx_frame_err) status_reg.framing <= 1'b1;
			else if (w0c_fer) status_reg.framing <= 1'b0;
			// no parity in multiprocessor format, so only the clear acts
			if (w0c_per) status_reg.parity <= 1'b0;
			if (rx_good || rx_frame_err) status_reg.mp_rx <= rx_mpb;
			if (status_wr) status_reg.mp_tx <= pwdata[BIT_MP_BIT_TO_SEND];
		end
	end

	// ----------------------------------------
	// request lines
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= '0;
		end else begin
			irq_reg.tx_empty_irq <= status_reg.tx_empty & control_reg[BIT_TX_IE];
			irq_reg.tx_done_irq  <= status_reg.tx_done & control_reg[BIT_TX_COMPLETE_FLAG_IE];
			irq_reg.rx_full_irq  <= status_reg.rx_full & control_reg[BIT_RX_IE];
			irq_reg.rx_error_irq <= (status_reg.overrun | status_reg.framing | status_reg.parity)
				& control_reg[BIT_RX_IE];
		end
	end
	assign irq_out = irq_reg;

endmodule // ast_serial
`default_nettype wire

// ---- testbench/ast_serial_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port-level checks on the serial block
// ----------------------------------------
module ast_serial_chk (
	input wire logic                       mclk,
	input wire logic                       rst_n,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [ast_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       gpio_dout,
	input wire logic                       gpio_oe,
	input wire logic                       serial_tx_out,
	input wire logic                       serial_tx_oe,
	input wire ast_pkg::ast_irq_t          irq_out
);
	import ast_pkg::*;
	logic        sel_reg;
	logic [7:0]  ctrl_reg;
	logic [1:0]  run_reg;
	logic [15:0] low_reg;
	// copies snooped off the bus, the checker cannot see inside
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_reg  <= 1'b0;
			ctrl_reg <= 8'h00;
		end else if (psel && penable && pwrite) begin
			if (paddr == {IDX_PORT_CTRL, 2'b00})
				sel_reg <= pwdata[BIT_PIN_SEL];
			if (paddr == {IDX_CONTROL, 2'b00})
				ctrl_reg <= pwdata[7:0];
		end
	end
	// low-run length; each bit must last a whole bit time
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 2'h0;
			low_reg <= 16'h0000;
		end else begin
			run_reg <= (run_reg == 2'h3) ? run_reg : run_reg + 2'h1;
			low_reg <= serial_tx_out ? 16'h0000 : low_reg + 16'h0001;
		end
	end
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	apb_ready_a: assert property (psel |-> pready) else $error("pready low in a transfer");
	err_data_a: assert property (psel && penable && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returned data");
	gpio_map_a: assert property (run_reg == 2'h3 && !sel_reg && $past(!sel_reg, 2)
		|-> serial_tx_out == $past(gpio_dout) && serial_tx_oe == $past(gpio_oe)) else $error("pin not general io");
	bit_time_a: assert property (sel_reg && $past(sel_reg) && $rose(serial_tx_out)
		|-> low_reg % 16'(BIT_CYCLES) == 16'h0000) else $error("low run not whole bits");
	tx_off_a: assert property (psel && penable && !pwrite && paddr == {IDX_STATUS, 2'b00}
		&& !ctrl_reg[BIT_TX_ON] && $past(!ctrl_reg[BIT_TX_ON], 3) |-> prdata[BIT_TX_BUFFER_EMPTY_FLAG] && prdata[BIT_TX_COMPLETE_FLAG])
		else $error("empty or end flag low with transmit off");
	txe_gate_a: assert property (!ctrl_reg[BIT_TX_IE] && $past(!ctrl_reg[BIT_TX_IE], 2)
		|-> !irq_out.tx_empty_irq) else $error("empty request while disabled");
	txd_gate_a: assert property (!ctrl_reg[BIT_TX_COMPLETE_FLAG_IE] && $past(!ctrl_reg[BIT_TX_COMPLETE_FLAG_IE], 2)
		|-> !irq_out.tx_done_irq) else $error("end request while disabled");
	rx_gate_a: assert property (!ctrl_reg[BIT_RX_IE] && $past(!ctrl_reg[BIT_RX_IE], 2)
		|-> !irq_out.rx_full_irq && !irq_out.rx_error_irq) else $error("receive request while disabled");
	txe_on_a: assert property (ctrl_reg[BIT_TX_IE] && !ctrl_reg[BIT_TX_ON]
		&& $past(ctrl_reg[BIT_TX_IE] && !ctrl_reg[BIT_TX_ON], 3) |-> irq_out.tx_empty_irq)
		else $error("empty request missing");
	frame_c: cover property (sel_reg && $rose(serial_tx_out));
	refuse_c: cover property (psel && penable && pslverr);
	rx_err_c: cover property (irq_out.rx_error_irq);
endmodule // ast_serial_chk
bind ast_serial ast_serial_chk ast_serial_chk_inst (
	.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_dout(gpio_dout),
	.gpio_oe(gpio_oe), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe), .irq_out(irq_out)
);
`default_nettype wire

// ---- testbench/ast_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// another station on the shared line
// ----------------------------------------
module ast_peer (
	input  wire logic mclk,
	input  wire logic line_in,
	output logic      line_out
);
	import ast_pkg::*;
	int         rx_cnt = 0;
	int         gap    = 0;
	int         cyc_n  = 0;
	int         last_s = 0;
	logic [7:0] rx_data;
	logic       rx_mp;
	logic       rx_stop;
	initial line_out = 1'b1;
	always @(posedge mclk) cyc_n <= cyc_n + 1;
	task automatic bit_out(input logic b);
		line_out <= b;
		repeat (BIT_CYCLES) @(posedge mclk);
	endtask
	// a low stop bit is how a framing fault is made
	task automatic send(input logic [7:0] d, input logic mp, input logic stop_ok);
		@(posedge mclk);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) bit_out(d[i]);
		bit_out(mp);
		bit_out(stop_ok);
		line_out <= 1'b1;
	endtask
	// samples mid-bit; start-to-start gap exposes idle time
	initial forever begin
		@(negedge line_in);
		gap = cyc_n - last_s;
		last_s = cyc_n;
		repeat (HALF_CYCLES) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge mclk);
			rx_data[i] = line_in;
		end
		repeat (BIT_CYCLES) @(posedge mclk);
		rx_mp = line_in;
		repeat (BIT_CYCLES) @(posedge mclk);
		rx_stop = line_in;
		rx_cnt++;
	end
endmodule // ast_peer
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench for the serial block
// ----------------------------------------
module tb_top;
	import ast_pkg::*;
	logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, low_power_req;
	logic              rx_line, gpio_dout, gpio_oe, serial_tx_out, serial_tx_oe, rerr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [7:0]        rdat;
	ast_irq_t          irq_out;
	int                num_errors = 0;
	int                num_checks = 0;
	int                tick = 0;
	ast_serial ast_serial_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_power_req(low_power_req), .serial_rx_in(rx_line), .gpio_dout(gpio_dout), .gpio_oe(gpio_oe),
		.serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe), .irq_out(irq_out));
	ast_peer ast_peer_inst (.mclk(mclk), .line_in(serial_tx_out), .line_out(rx_line));
	task automatic results();
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic ck(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		ck($sformatf("reg_%h", i), {8'h00, rdat & m}, {8'h00, e});
	endtask
	task automatic t_reset();
		rd(IDX_STATUS, 8'hff, 8'h84);
		rd(IDX_HOLDING, 8'hff, 8'hff);
		apb(1'b0, 16'hff9f, 8'h00);
		ck("unmapped", {7'h00, rerr, rdat}, 16'h0100);
		apb(1'b1, IDX_STATUS, 8'hfe);
		rd(IDX_STATUS, 8'hff, 8'h84);
		apb(1'b1, IDX_HOLDING, 8'h5a);
		rd(IDX_HOLDING, 8'hff, 8'h5a);
		low_power_req <= 1'b1;
		cyc(2);
		low_power_req <= 1'b0;
		rd(IDX_HOLDING, 8'hff, 8'hff);
	endtask
	task automatic t_tx();
		apb(1'b1, IDX_PORT_CTRL, 8'h10);
		apb(1'b1, IDX_CONTROL, 8'h30);
		apb(1'b1, IDX_STATUS, 8'hfd);
		fork
			ast_peer_inst.send(8'h22, 1'b0, 1'b1);
		join_none
		rd(IDX_STATUS, 8'h84, 8'h84);
		apb(1'b1, IDX_HOLDING, 8'hb8);
		cyc(4);
		rd(IDX_STATUS, 8'h84, 8'h80);
		apb(1'b1, IDX_HOLDING, 8'hde);
		apb(1'b1, IDX_STATUS, 8'hfc);
		rd(IDX_STATUS, 8'h80, 8'h00);
		wait (ast_peer_inst.rx_cnt == 1);
		ck("frame1", {7'h00, ast_peer_inst.rx_mp, ast_peer_inst.rx_data}, 16'h01b8);
		wait (ast_peer_inst.rx_cnt == 2);
		ck("frame2", {6'h00, ast_peer_inst.rx_stop, ast_peer_inst.rx_mp, ast_peer_inst.rx_data}, 16'h02de);
		ck("gap", 16'(ast_peer_inst.gap), 16'(11 * BIT_CYCLES));
		cyc(1000);
		rd(IDX_STATUS, 8'hc4, 8'hc4);
	endtask
	task automatic t_irq();
		apb(1'b1, IDX_CONTROL, 8'hb4);
		cyc(3);
		ck("irq", {12'h000, irq_out}, 16'h000c);
		apb(1'b0, IDX_STATUS, 8'h00);
		apb(1'b1, IDX_STATUS, 8'h7d);
		// empty flag cleared with tx_on high means a character waits, so the shifter reloads it
		rd(IDX_STATUS, 8'h84, 8'h80);
		cyc(3);
		ck("irq", {12'h000, irq_out}, 16'h0008);
		apb(1'b1, IDX_CONTROL, 8'h90);
		cyc(3);
		rd(IDX_STATUS, 8'h84, 8'h84);
		ck("irq", {12'h000, irq_out}, 16'h0008);
	endtask
	task automatic t_rx();
		apb(1'b1, IDX_CONTROL, 8'h50);
		ast_peer_inst.send(8'h33, 1'b0, 1'b1);
		rd(IDX_STATUS, 8'h60, 8'h60);
		ck("irq", {12'h000, irq_out}, 16'h0003);
		rd(IDX_RX_HOLD, 8'hff, 8'h22);
		rd(IDX_STATUS, 8'h40, 8'h00);
		apb(1'b1, IDX_CONTROL, 8'h40);
		rd(IDX_STATUS, 8'h20, 8'h20);
		apb(1'b1, IDX_CONTROL, 8'h50);
		ast_peer_inst.send(8'h44, 1'b0, 1'b0);
		rd(IDX_STATUS, 8'h70, 8'h20);
		rd(IDX_RX_HOLD, 8'hff, 8'h22);
		apb(1'b1, IDX_STATUS, 8'hfd);
		apb(1'b1, IDX_STATUS, 8'hdd);
		rd(IDX_STATUS, 8'h20, 8'h20);
		apb(1'b1, IDX_STATUS, 8'hdd);
		rd(IDX_STATUS, 8'h20, 8'h00);
		ast_peer_inst.send(8'h55, 1'b0, 1'b0);
		rd(IDX_STATUS, 8'h70, 8'h10);
		rd(IDX_RX_HOLD, 8'hff, 8'h55);
		apb(1'b1, IDX_CONTROL, 8'h40);
		rd(IDX_STATUS, 8'h10, 8'h10);
	endtask
	task automatic t_gpio();
		apb(1'b1, IDX_PORT_CTRL, 8'h00);
		gpio_oe <= 1'b1;
		gpio_dout <= 1'b0;
		cyc(3);
		ck("pin", {14'h0000, serial_tx_out, serial_tx_oe}, 16'h0001);
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ceiling sits just above the five frame times the run needs
	always @(posedge mclk) begin
		tick++;
		if (tick == 98_000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0000_0000;
		low_power_req = 1'b0;
		gpio_dout = 1'b1;
		gpio_oe = 1'b0;
		cyc(10);
		rst_n <= 1'b1;
		t_reset();
		t_tx();
		t_irq();
		t_rx();
		t_gpio();
		results();
	end
endmodule // tb_top
`default_nettype wire
